//--- core/stack_interp_params.svh
// Offsets, field positions, packet codes and reset values of the stack command interpreter
`ifndef STACK_INTERP_PARAMS_SVH
`define STACK_INTERP_PARAMS_SVH

// Packet header targets and flags
`define HDR_TARGET_REGS     16'h0001
`define HDR_TARGET_MAIN     16'h0002
`define HDR_TARGET_AUX      16'h0003
`define HDR_TARGET_GEN      16'h0008
`define HDR_REQUEST_BIT     2
`define SUBADDR_ACTION      16'h000a

// Mode word fields
`define MODE_AM_HI          5
`define MODE_DS0_BIT        6
`define MODE_DS1_BIT        7
`define MODE_RNW_BIT        8
`define MODE_BE_BIT         16
`define MODE_HD_BIT         17
`define MODE_ND_BIT         18
`define MODE_HM_BIT         19
`define MODE_NT_LO          22
`define MODE_BLT_LO         24

// Block transfer address modifiers
`define AM_BLT_A24_USER     6'h3b
`define AM_BLT_A24_SUPV     6'h3f
`define AM_BLT_A32_USER     6'h0b
`define AM_BLT_A32_SUPV     6'h0f
`define BLT_ADDR_STEP       32'h0000_0004

// Wishbone register offsets
`define REG_CTRL            4'h0
`define REG_COUNT_MASK      4'h4
`define REG_STATUS          4'h8
`define REG_HIT             4'hc

// Control register bits
`define CTRL_ACQ_BIT        0
`define CTRL_AUX_GO_BIT     1

// Reset values
`define RST_COUNT_MASK      32'h0000_00ff
`define RST_ACTION          8'h00

`endif

//--- core/stack_interp_pkg.sv
// Types shared by the stack command interpreter
package stack_interp_pkg;

  typedef enum logic [1:0] {
    SRC_GEN,
    SRC_MAIN,
    SRC_AUX
  } src_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [5:0]  am;
    logic [31:0] addr;
    logic        lword;
    logic [1:0]  ds_n;
    logic [31:0] wdata;
  } bus_req_type;

endpackage : stack_interp_pkg

//--- core/stack_interp.sv
// Command packet parser, command stacks and bus-cycle interpreter
//
// Function
// - Action write: target, sub-address 10, 8-bit data
// - Action read-back: header 5, sub-address 10
// - Header 2 main, 3 auxiliary, 8 generator
// - Stack packet: count, zero word, 32-bit words
// - Main stack 384 words, runs on trigger
// - Auxiliary stack 128 words, periodic readout; here run once per control register write with bits 0 and 1 set
// - Stacks in acquisition, packet in interactive; here the generator packet also runs in acquisition
// - Command: mode word then address word
// - Mode: modifier, strobe suppress, ignored bits
// - Mode bit 8 selects read or write
// - Mode bit 16 selects big endian
// - Bit 17 keeps read as hit pattern
// - Bit 18 masks read into next count
// - Bit 19 conditions; bits 23-22 mask count
// - Execute if any mask fully hit
// - Bits 31-24 give block transfer count
// - Address word; bit 0 drives LWORD
// - Write bytes placed per order and strobes
// - Read data packed from lowest byte
// - Header bit value 4 marks request
// - Generator packet returns bus data to host
//
// The Wishbone register port and the placing of the registers were decided locally.
`include "stack_interp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module stack_interp #(
  parameter int MAIN_DEPTH = 384,
  parameter int AUX_DEPTH  = 128,
  parameter int GEN_DEPTH  = 128
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [3:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [15:0]                out_data_i,
  input  wire logic                       out_valid_i,
  output logic                            out_ready_o,
  output logic      [15:0]                in_data_o,
  output logic                            in_valid_o,
  input  wire logic                       in_ready_i,
  input  wire logic                       event_trigger_i,
  output stack_interp_pkg::bus_req_type   bus_o,
  input  wire logic                       bus_ack_i,
  input  wire logic [31:0]                bus_rdata_i,
  output logic      [7:0]                 action_o,
  output logic                            busy_o
);

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  typedef enum {P_HDR, P_SUB, P_DATA, P_CNT, P_ZERO, P_LO, P_HI, P_REPLY, P_RUN} pstate_type;
  typedef enum {X_IDLE, X_MODE, X_ADDR, X_MASK, X_GO, X_BUS, X_REL,
                X_PUSH_LO, X_PUSH_HI, X_NEXT} xstate_type;

  logic [31:0] main_mem [MAIN_DEPTH];
  logic [31:0] aux_mem  [AUX_DEPTH];
  logic [31:0] gen_mem  [GEN_DEPTH];

  pstate_type                 pstate_r;
  xstate_type                 xstate_r;
  stack_interp_pkg::src_type  load_src_r;
  stack_interp_pkg::src_type  src_r;
  logic [15:0] hdr_r;
  logic [15:0] remain_r;
  logic [15:0] lo_r;
  logic [8:0]  wr_idx_r;
  logic [8:0]  main_len_r;
  logic [8:0]  aux_len_r;
  logic [8:0]  gen_len_r;
  logic [8:0]  idx_r;
  logic [8:0]  len_r;
  logic [7:0]  action_r;
  logic        acq_r;
  logic        aux_go_r;
  logic [31:0] count_mask_r;
  logic [31:0] mode_r;
  logic [31:0] addr_r;
  logic [8:0]  xfers_r;
  logic [2:0]  masks_left_r;
  logic        hit_ok_r;
  logic [15:0] hit_r;
  logic [7:0]  ovr_r;
  logic        ovr_valid_r;
  logic        wide_r;
  logic [15:0] hi_half_r;
  logic [15:0] out_data_r;
  logic        bus_req_r;
  logic [31:0] wdata_r;
  logic        wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [2:0]  trig_sync_r;
  logic [1:0]  ack_sync_r;
  logic [31:0] cur_word;
  logic        take_word;
  logic        is_request;
  logic        gen_start;
  logic        is_blt;
  logic        cond_ok;
  logic [31:0] read_word;
  logic        read_wide;
  logic        wb_req;

  assign take_word  = out_valid_i && out_ready_o;
  assign is_request = out_data_i[`HDR_REQUEST_BIT];
  assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_r;
  assign gen_start  = (pstate_r == P_RUN);
  assign is_blt     = (mode_r[`MODE_AM_HI:0] == `AM_BLT_A24_USER) ||
                      (mode_r[`MODE_AM_HI:0] == `AM_BLT_A24_SUPV) ||
                      (mode_r[`MODE_AM_HI:0] == `AM_BLT_A32_USER) ||
                      (mode_r[`MODE_AM_HI:0] == `AM_BLT_A32_SUPV);
  assign cond_ok    = !mode_r[`MODE_HM_BIT] || hit_ok_r;

  always_comb begin
    unique case (src_r)
      stack_interp_pkg::SRC_MAIN: cur_word = main_mem[idx_r];
      stack_interp_pkg::SRC_AUX:  cur_word = aux_mem[idx_r[6:0]];
      default:                    cur_word = gen_mem[idx_r[6:0]];
    endcase
  end

  // ---------------------------------------------------------------
  // Byte lane placement and read packing
  // ---------------------------------------------------------------
  function automatic logic [31:0] place(input logic [31:0] d, input logic [4:0] k);
    logic [7:0] b0, b1, b2, b3;
    b0 = d[7:0];
    b1 = d[15:8];
    b2 = d[23:16];
    b3 = d[31:24];
    unique case (k)  // {order, ds1, ds0, a1, lword}
      5'h10:   place = {b0, b1, b2, b3};
      5'h14:   place = {b0, b1, b2, 8'h00};
      5'h18:   place = {8'h00, b1, b2, b3};
      5'h12:   place = {8'h00, b1, b2, 8'h00};
      5'h13:   place = {16'h0000, b2, b3};
      5'h11:   place = {16'h0000, b0, b1};
      5'h1b:   place = {24'h000000, b3};
      5'h17:   place = {16'h0000, b2, 8'h00};
      5'h19:   place = {24'h000000, b1};
      5'h15:   place = {16'h0000, b0, 8'h00};
      5'h04:   place = {b2, b1, b0, 8'h00};
      5'h08:   place = {8'h00, b3, b2, b1};
      5'h02:   place = {8'h00, b2, b1, 8'h00};
      5'h03:   place = {16'h0000, b3, b2};
      5'h01:   place = {16'h0000, b1, b0};
      5'h0b:   place = {24'h000000, b0};
      5'h07:   place = {16'h0000, b1, 8'h00};
      5'h09:   place = {24'h000000, b2};
      5'h05:   place = {16'h0000, b3, 8'h00};
      default: place = k[4] ? {b0, b1, b2, b3} : d;
    endcase
  endfunction : place

  // One live lane gives a byte, two a half word, four a full word
  always_comb begin
    logic [31:0] o;
    o = mode_r[`MODE_BE_BIT] ? {bus_rdata_i[7:0], bus_rdata_i[15:8],
                                bus_rdata_i[23:16], bus_rdata_i[31:24]} : bus_rdata_i;
    read_wide = 1'b0;
    if (mode_r[`MODE_DS1_BIT] && !mode_r[`MODE_DS0_BIT])
      read_word = {24'h000000, addr_r[0] ? bus_rdata_i[7:0] : bus_rdata_i[15:8]};
    else if (!mode_r[`MODE_DS1_BIT] && mode_r[`MODE_DS0_BIT])
      read_word = {24'h000000, addr_r[0] ? bus_rdata_i[15:8] : bus_rdata_i[23:16]};
    else if (addr_r[0] || addr_r[1])
      read_word = {16'h0000, addr_r[0] ? (mode_r[`MODE_BE_BIT] ? o[31:16] : o[15:0])
                                       : (mode_r[`MODE_BE_BIT] ? o[23:8] : o[23:8])};
    else begin
      read_word = o;
      read_wide = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_sync_r <= 3'h0;
      ack_sync_r  <= 2'h0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], event_trigger_i};
      ack_sync_r  <= {ack_sync_r[0], bus_ack_i};
    end
  end

  // ---------------------------------------------------------------
  // Packet parser
  // ---------------------------------------------------------------
  always_comb begin
    unique case (pstate_r)
      P_REPLY, P_RUN: out_ready_o = 1'b0;
      P_HDR:          out_ready_o = (xstate_r == X_IDLE);
      default:        out_ready_o = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pstate_r   <= P_HDR;
      hdr_r      <= 16'h0000;
      remain_r   <= 16'h0000;
      lo_r       <= 16'h0000;
      wr_idx_r   <= 9'h000;
      load_src_r <= stack_interp_pkg::SRC_GEN;
      main_len_r <= 9'h000;
      aux_len_r  <= 9'h000;
      gen_len_r  <= 9'h000;
      action_r   <= `RST_ACTION;
    end else begin
      unique case (pstate_r)
        P_HDR: if (take_word) begin
          hdr_r <= out_data_i;
          unique case (out_data_i & ~(16'h0001 << `HDR_REQUEST_BIT))
            `HDR_TARGET_REGS: pstate_r <= P_SUB;
            `HDR_TARGET_MAIN: begin
              load_src_r <= stack_interp_pkg::SRC_MAIN;
              pstate_r   <= is_request ? P_HDR : P_CNT;
            end
            `HDR_TARGET_AUX: begin
              load_src_r <= stack_interp_pkg::SRC_AUX;
              pstate_r   <= is_request ? P_HDR : P_CNT;
            end
            `HDR_TARGET_GEN: begin
              load_src_r <= stack_interp_pkg::SRC_GEN;
              pstate_r   <= P_CNT;
            end
            default: pstate_r <= P_HDR;
          endcase
        end
        P_SUB: if (take_word) begin
          if (out_data_i != `SUBADDR_ACTION)
            pstate_r <= hdr_r[`HDR_REQUEST_BIT] ? P_HDR : P_DATA;
          else
            pstate_r <= hdr_r[`HDR_REQUEST_BIT] ? P_REPLY : P_DATA;
          lo_r <= out_data_i;
        end
        P_DATA: if (take_word) begin
          if (lo_r == `SUBADDR_ACTION)
            action_r <= out_data_i[7:0];
          pstate_r <= P_HDR;
        end
        P_CNT: if (take_word) begin
          remain_r <= out_data_i;
          wr_idx_r <= 9'h000;
          pstate_r <= (out_data_i == 16'h0000) ? P_HDR : P_ZERO;
        end
        P_ZERO: if (take_word) begin
          remain_r <= remain_r - 16'h0001;
          pstate_r <= (remain_r == 16'h0001) ? P_HDR : P_LO;
        end
        P_LO: if (take_word) begin
          lo_r     <= out_data_i;
          remain_r <= remain_r - 16'h0001;
          pstate_r <= (remain_r == 16'h0001) ? P_HDR : P_HI;
        end
        P_HI: if (take_word) begin
          unique case (load_src_r)
            stack_interp_pkg::SRC_MAIN: begin
              if (32'(wr_idx_r) < MAIN_DEPTH)
                main_len_r <= wr_idx_r + 9'h001;
            end
            stack_interp_pkg::SRC_AUX: begin
              if (32'(wr_idx_r) < AUX_DEPTH)
                aux_len_r <= wr_idx_r + 9'h001;
            end
            default: begin
              if (32'(wr_idx_r) < GEN_DEPTH)
                gen_len_r <= wr_idx_r + 9'h001;
            end
          endcase
          wr_idx_r <= wr_idx_r + 9'h001;
          remain_r <= remain_r - 16'h0001;
          if (remain_r == 16'h0001)
            pstate_r <= (load_src_r == stack_interp_pkg::SRC_GEN) ? P_RUN : P_HDR;
          else
            pstate_r <= P_LO;
        end
        P_REPLY: if (in_ready_i)
          pstate_r <= P_HDR;
        P_RUN: pstate_r <= P_HDR;
      endcase
      if (pstate_r == P_CNT && take_word) begin
        unique case (load_src_r)
          stack_interp_pkg::SRC_MAIN: main_len_r <= 9'h000;
          stack_interp_pkg::SRC_AUX:  aux_len_r  <= 9'h000;
          default:                    gen_len_r  <= 9'h000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (pstate_r == P_HI && take_word) begin
      unique case (load_src_r)
        stack_interp_pkg::SRC_MAIN: if (32'(wr_idx_r) < MAIN_DEPTH)
          main_mem[wr_idx_r] <= {out_data_i, lo_r};
        stack_interp_pkg::SRC_AUX: if (32'(wr_idx_r) < AUX_DEPTH)
          aux_mem[wr_idx_r[6:0]] <= {out_data_i, lo_r};
        default: if (32'(wr_idx_r) < GEN_DEPTH)
          gen_mem[wr_idx_r[6:0]] <= {out_data_i, lo_r};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command interpreter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xstate_r     <= X_IDLE;
      src_r        <= stack_interp_pkg::SRC_GEN;
      idx_r        <= 9'h000;
      len_r        <= 9'h000;
      mode_r       <= 32'h0000_0000;
      addr_r       <= 32'h0000_0000;
      xfers_r      <= 9'h000;
      masks_left_r <= 3'h0;
      hit_ok_r     <= 1'b0;
      hit_r        <= 16'h0000;
      ovr_r        <= 8'h00;
      ovr_valid_r  <= 1'b0;
      wide_r       <= 1'b0;
      hi_half_r    <= 16'h0000;
      bus_req_r    <= 1'b0;
      wdata_r      <= 32'h0000_0000;
    end else begin
      unique case (xstate_r)
        X_IDLE: begin
          idx_r <= 9'h000;
          if (gen_start) begin
            src_r    <= stack_interp_pkg::SRC_GEN;
            len_r    <= gen_len_r;
            xstate_r <= X_MODE;
          end else if (acq_r && trig_sync_r[1] && !trig_sync_r[2] && pstate_r == P_HDR) begin
            src_r    <= stack_interp_pkg::SRC_MAIN;
            len_r    <= main_len_r;
            xstate_r <= X_MODE;
          end else if (acq_r && aux_go_r && pstate_r == P_HDR) begin
            src_r    <= stack_interp_pkg::SRC_AUX;
            len_r    <= aux_len_r;
            xstate_r <= X_MODE;
          end
        end
        X_MODE: begin
          if (idx_r >= len_r)
            xstate_r <= X_IDLE;
          else begin
            mode_r   <= cur_word;
            idx_r    <= idx_r + 9'h001;
            xstate_r <= X_ADDR;
          end
        end
        X_ADDR: begin
          addr_r   <= cur_word;
          idx_r    <= idx_r + 9'h001;
          hit_ok_r <= 1'b0;
          xfers_r  <= 9'h001;
          if (is_blt) begin
            xfers_r     <= {1'b0, ovr_valid_r ? ovr_r : mode_r[31:`MODE_BLT_LO]};
            ovr_valid_r <= 1'b0;
          end
          masks_left_r <= (mode_r[`MODE_NT_LO+1:`MODE_NT_LO] == 2'h0) ? 3'h4
                          : {1'b0, mode_r[`MODE_NT_LO+1:`MODE_NT_LO]};
          xstate_r <= mode_r[`MODE_HM_BIT] ? X_MASK : X_GO;
        end
        X_MASK: begin
          if ((cur_word & {16'h0000, hit_r}) == cur_word)
            hit_ok_r <= 1'b1;
          idx_r        <= idx_r + 9'h001;
          masks_left_r <= masks_left_r - 3'h1;
          if (masks_left_r == 3'h1)
            xstate_r <= X_GO;
        end
        X_GO: begin
          if (!cond_ok) begin
            if (!mode_r[`MODE_RNW_BIT])
              idx_r <= idx_r + xfers_r;
            xstate_r <= X_MODE;
          end else if (xfers_r == 9'h000)
            xstate_r <= X_MODE;
          else begin
            if (!mode_r[`MODE_RNW_BIT]) begin
              wdata_r <= place(cur_word, {mode_r[`MODE_BE_BIT], mode_r[`MODE_DS1_BIT],
                                         mode_r[`MODE_DS0_BIT], addr_r[1], addr_r[0]});
              idx_r   <= idx_r + 9'h001;
            end
            bus_req_r <= 1'b1;
            xstate_r  <= X_BUS;
          end
        end
        X_BUS: if (ack_sync_r[1]) begin
          bus_req_r <= 1'b0;
          xstate_r  <= X_REL;
          if (mode_r[`MODE_RNW_BIT]) begin
            wide_r    <= read_wide;
            hi_half_r <= read_word[31:16];
            if (mode_r[`MODE_HD_BIT])
              hit_r <= read_word[15:0];
            if (mode_r[`MODE_ND_BIT]) begin
              ovr_r       <= bus_rdata_i[7:0] & count_mask_r[7:0];
              ovr_valid_r <= 1'b1;
            end
          end
        end
        X_REL: if (!ack_sync_r[1])
          xstate_r <= mode_r[`MODE_RNW_BIT] ? X_PUSH_LO : X_NEXT;
        X_PUSH_LO: if (in_ready_i)
          xstate_r <= wide_r ? X_PUSH_HI : X_NEXT;
        X_PUSH_HI: if (in_ready_i)
          xstate_r <= X_NEXT;
        X_NEXT: begin
          xfers_r <= xfers_r - 9'h001;
          addr_r  <= addr_r + `BLT_ADDR_STEP;
          xstate_r <= (xfers_r > 9'h001) ? X_GO : X_MODE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Host output stream
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i)
      out_data_r <= 16'h0000;
    else if (pstate_r == P_SUB)
      out_data_r <= {8'h00, action_r};
    else if (xstate_r == X_BUS && ack_sync_r[1])
      out_data_r <= read_word[15:0];
    else if (xstate_r == X_PUSH_LO && in_ready_i)
      out_data_r <= hi_half_r;
  end

  assign in_valid_o = (pstate_r == P_REPLY) || (xstate_r == X_PUSH_LO) ||
                      (xstate_r == X_PUSH_HI);
  assign in_data_o  = out_data_r;

  // ---------------------------------------------------------------
  // Wishbone registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r     <= 1'b0;
      wb_dat_r     <= 32'h0000_0000;
      acq_r        <= 1'b0;
      aux_go_r     <= 1'b0;
      count_mask_r <= `RST_COUNT_MASK;
    end else begin
      wb_ack_r <= wb_req;
      if (xstate_r == X_IDLE && aux_go_r && acq_r &&
          pstate_r == P_HDR && !gen_start && !(trig_sync_r[1] && !trig_sync_r[2]))
        aux_go_r <= 1'b0;
      if (!acq_r)
        aux_go_r <= 1'b0;
      if (wb_req && wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CTRL: if (wb_sel_i[0]) begin
            acq_r <= wb_dat_i[`CTRL_ACQ_BIT];
            if (wb_dat_i[`CTRL_AUX_GO_BIT])
              aux_go_r <= 1'b1;
          end
          `REG_COUNT_MASK: for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i])
              count_mask_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
          end
          default: ;
        endcase
      end
      unique case (wb_adr_i)
        `REG_CTRL:       wb_dat_r <= {31'h0000_0000, acq_r};
        `REG_COUNT_MASK: wb_dat_r <= count_mask_r;
        `REG_STATUS:     wb_dat_r <= {16'h0000, action_r, 6'h00, ovr_valid_r, busy_o};
        `REG_HIT:        wb_dat_r <= {16'h0000, hit_r};
        default:         wb_dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign action_o = action_r;
  assign busy_o   = (xstate_r != X_IDLE);

  assign bus_o.req   = bus_req_r;
  assign bus_o.write = !mode_r[`MODE_RNW_BIT];
  assign bus_o.am    = mode_r[`MODE_AM_HI:0];
  assign bus_o.addr  = addr_r;
  assign bus_o.lword = addr_r[0];
  assign bus_o.ds_n  = {mode_r[`MODE_DS1_BIT], mode_r[`MODE_DS0_BIT]};
  assign bus_o.wdata = wdata_r;

endmodule : stack_interp

`default_nettype wire

//--- test/stack_interp_asserts.sv
// Port-level checks of the stack command interpreter
`timescale 1ns/1ps
`default_nettype none
module stack_interp_asserts (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic [3:0]                    wb_adr_i,
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          wb_ack_o,
  input wire logic                          out_ready_o,
  input wire logic [15:0]                   in_data_o,
  input wire logic                          in_valid_o,
  input wire logic                          in_ready_i,
  input wire stack_interp_pkg::bus_req_type bus_o,
  input wire logic                          bus_ack_i,
  input wire logic [7:0]                    action_o,
  input wire logic                          busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_unmapped_zero: assert property (wb_ack_o && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_lword_addr: assert property (bus_o.req |-> bus_o.lword == bus_o.addr[0])
    else $error("lword differs from address bit 0");
  chk_bus_stable: assert property (bus_o.req && $past(bus_o.req) |-> $stable(bus_o))
    else $error("bus request changed while pending");
  chk_req_waits: assert property (bus_o.req && !bus_ack_i |=> bus_o.req)
    else $error("bus request dropped without ack");
  chk_four_phase: assert property (!bus_o.req && bus_ack_i |=> !bus_o.req)
    else $error("new bus request before ack released");
  chk_req_busy: assert property (bus_o.req |-> busy_o)
    else $error("bus request while idle");
  chk_reply_holds: assert property (in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_data_o))
    else $error("reply word not held");
  chk_reset_idle: assert property ($fell(rst_i) |-> action_o == 8'h00 && out_ready_o && !bus_o.req)
    else $error("outputs not idle after reset");
  cov_action: cover property (action_o != 8'h00);
  cov_read: cover property (bus_o.req && !bus_o.write);
  cov_write: cover property (bus_o.req && bus_o.write);
endmodule : stack_interp_asserts
bind stack_interp stack_interp_asserts i_stack_interp_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .out_ready_o(out_ready_o), .in_data_o(in_data_o),
  .in_valid_o(in_valid_o), .in_ready_i(in_ready_i), .bus_o(bus_o), .bus_ack_i(bus_ack_i),
  .action_o(action_o), .busy_o(busy_o));
`default_nettype wire

//--- test/vme_slave_model.sv
// Behavioural bus slave answering the interpreter's cycles
`timescale 1ns/1ps
`default_nettype none
module vme_slave_model (
  input  wire logic                          clk_i,
  input  wire stack_interp_pkg::bus_req_type bus_i,
  input  wire logic [31:0]                   rdata_val_i,
  output logic                               ack_o,
  output logic [31:0]                        rdata_o,
  output stack_interp_pkg::bus_req_type      last_o,
  output int                                 count_o
);
  int wait_r = 0;
  initial ack_o = 0;
  initial rdata_o = 0;
  initial count_o = 0;
  // Four-phase answer, slow on every other transfer
  always @(posedge clk_i) begin
    if (bus_i.req && !ack_o) begin
      wait_r <= wait_r + 1;
      if (wait_r >= (count_o % 2) * 3) begin
        ack_o <= 1;
        rdata_o <= rdata_val_i;
        last_o <= bus_i;
        count_o <= count_o + 1;
        wait_r <= 0;
      end
    end else if (!bus_i.req && ack_o) begin
      ack_o <= 0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : vme_slave_model
`default_nettype wire

//--- test/stack_interp_bench.sv
// Self-checking bench of the stack command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "stack_interp_params.svh"
module stack_interp_bench;
  logic                          clk_i = 0;
  logic                          rst_i = 1;
  logic                          cyc = 0, stb = 0, we = 0, ov = 0, trg = 0, rdy = 1;
  logic [3:0]                    adr = 0;
  logic [31:0]                   wdat = 0, rdat, r, brd, rv = 32'h1234_5678;
  logic [15:0]                   od = 0, id;
  logic [7:0]                    act;
  logic                          ack, ordy, ival, busy, back;
  stack_interp_pkg::bus_req_type bus, last;
  int                            failures = 0, total_checks = 0, ticks = 0, n, n0;
  logic [15:0]                   rq[$];
  stack_interp i_stack_interp (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .out_data_i(od), .out_valid_i(ov), .out_ready_o(ordy), .in_data_o(id),
    .in_valid_o(ival), .in_ready_i(rdy), .event_trigger_i(trg), .bus_o(bus),
    .bus_ack_i(back), .bus_rdata_i(brd), .action_o(act), .busy_o(busy));
  vme_slave_model i_vme_slave_model (.clk_i(clk_i), .bus_i(bus), .rdata_val_i(rv),
    .ack_o(back), .rdata_o(brd), .last_o(last), .count_o(n));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ival === 1'b1 && rdy === 1'b1) rq.push_back(id);
    if (ticks == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic put(input logic [15:0] w);
    od <= w;
    ov <= 1;
    do @(posedge clk_i); while (ordy !== 1'b1);
  endtask : put
  task automatic settle();
    repeat (8) @(posedge clk_i);
    while (busy !== 1'b0) @(posedge clk_i);
  endtask : settle
  task automatic pkt(input logic [15:0] h, input logic [31:0] w[$]);
    put(h);
    put(16'(2 * w.size() + 1));
    put(16'h0);
    foreach (w[i]) begin
      put(w[i][15:0]);
      put(w[i][31:16]);
    end
    ov <= 0;
    settle();
  endtask : pkt
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `REG_COUNT_MASK, 0);
    chk(r, `RST_COUNT_MASK);
    wb(0, 4'h2, 0);
    put(16'h0001);
    put(16'h000a);
    put(16'h005a);
    ov <= 0;
    wb(0, `REG_STATUS, 0);
    chk({r[15:8], act}, 16'h5a5a);
    rdy <= 0;
    put(16'h0005);
    put(16'h000a);
    ov <= 0;
    repeat (6) @(posedge clk_i);
    rdy <= 1;
    repeat (4) @(posedge clk_i);
    chk(rq.size(), 1);
    chk(rq.pop_front(), 16'h005a);
    pkt(8, '{32'h0000_0009, 32'h7800_0020, 32'haaaa_ffff});
    chk({last.write, last.am, last.addr[24:0]}, {1'b1, 6'h09, 25'h0000020});
    chk(last.wdata, 32'haaaa_ffff);
    pkt(8, '{32'h0001_0049, 32'h7800_0020, 32'haaaa_ffff});
    chk({last.ds_n, last.wdata[31:8]}, {2'h1, 24'hffff_aa});
    rq.delete();
    pkt(8, '{32'h0002_0109, 32'h7800_0120});
    chk(last.write, 0);
    chk(rq.size(), 2);
    chk({rq[0], rq[1]}, 32'h5678_1234);
    wb(0, `REG_HIT, 0);
    chk(r[15:0], 16'h5678);
    for (int k = 0; k < 2; k++) begin
      n0 = n;
      pkt(8, '{32'h0048_0009, 32'h7800_0030, 32'(8 >> (3 * k)), 32'h11});
      chk(n - n0, k == 0);
    end
    rv <= 32'h3;
    pkt(8, '{32'h0004_0109, 32'h7800_0120});
    n0 = n;
    pkt(8, '{32'h0100_010b, 32'h7800_0100});
    chk(n - n0, 3);
    chk(last.addr, 32'h7800_0108);
    n0 = n;
    pkt(2, '{32'h0000_0009, 32'h7800_0040, 32'h0});
    chk(n - n0, 0);
    wb(1, `REG_CTRL, 1);
    trg <= 1;
    repeat (4) @(posedge clk_i);
    trg <= 0;
    settle();
    chk(last.addr, 32'h7800_0040);
    pkt(3, '{32'h0000_0009, 32'h7800_0044, 32'h0});
    wb(1, `REG_CTRL, 3);
    settle();
    chk(last.addr, 32'h7800_0044);
    tally_and_finish();
  end
endmodule : stack_interp_bench
`default_nettype wire
